// ### logic/ssr_pkg.sv
// Purpose: shared constants and types of the safe position and stop reset block
// Assumes: one logic clock at SYS_CLK_HZ
// Notes:   register offsets are byte addresses on a 32-bit classic Wishbone bus
package ssr_pkg;
    // ==================================================================
    // timing
    localparam int unsigned SYS_CLK_HZ = 100_000_000;
    localparam int unsigned PULSE_MIN_MS = 100;
    // least time: exact here, so rounding up changes nothing
    localparam int unsigned PULSE_MIN_CYC = (SYS_CLK_HZ / 1000) * PULSE_MIN_MS;
    localparam int unsigned LAMP_HZ = 1;
    localparam int unsigned LAMP_HALF_CYC = SYS_CLK_HZ / (2 * LAMP_HZ);

    // ==================================================================
    // sizes
    localparam int unsigned MSG_INPUTS = 8;
    localparam int unsigned HIST_DEPTH = 8;

    // ==================================================================
    // register offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MSG_EDGE = 8'h04;
    localparam logic [7:0] ADDR_MSG_EN = 8'h08;
    localparam logic [7:0] ADDR_HIST = 8'h0c;
    localparam logic [7:0] ADDR_HIST_CNT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h1c;

    // ==================================================================
    // reset values: bit set in edge register means falling edge
    localparam logic [7:0] MSG_EDGE_RST = 8'h0c;
    localparam logic [7:0] MSG_EN_RST = 8'hff;

    // ==================================================================
    // status register bits
    localparam int unsigned ST_SAFE = 0;
    localparam int unsigned ST_INHIBIT = 1;
    localparam int unsigned ST_RESET_EN = 2;
    localparam int unsigned ST_RESTART_EN = 3;
    localparam int unsigned ST_ESTOP = 4;
    localparam int unsigned ST_MOTION = 5;
    // history read: valid flag above the mask
    localparam int unsigned HIST_VALID = 8;

    // ==================================================================
    // interrupt event bits
    localparam int unsigned EV_STOP = 0;
    localparam int unsigned EV_RESET = 1;
    localparam int unsigned EV_RESTART = 2;
    localparam int unsigned EV_MSG = 3;
    localparam int unsigned EV_UNSAFE = 4;
    localparam int unsigned EV_W = 5;

    // ==================================================================
    // types
    typedef enum logic [1:0] {
        STG_STOPPED = 2'b00,
        STG_RESET_OK = 2'b01,
        STG_RUN = 2'b10
    } ssr_stage_t;

    typedef struct packed {
        logic monitor_ok;
        logic cross_check_ok;
        logic absolute_position_trust;
        logic plausibility_fault;
        logic second_sensor_selftest_fault;
        logic sensor_identity_fault;
        logic second_sensor_selftest_on;
    } ssr_pos_in_t;

    typedef struct packed {
        logic estop_ok;
        logic stop1_reset_request;
        logic stop1_restart_request;
    } ssr_pin_t;
endpackage : ssr_pkg

// ### logic/ssr_sync.sv
// Purpose: pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to i_sys_clk
// Notes:   output moves only when stages two and three agree
module ssr_sync
    import ssr_pkg::*;
#(
    parameter int unsigned W = 3
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    // ==================================================================
    // state
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } ssr_sync_st_t;

    ssr_sync_st_t s;
    ssr_sync_st_t next_s;

    // s1 feeds only s2; the filter looks at s2 and s3
    always_comb begin
        next_s = s;
        next_s.s1 = i_async;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.q = (s.s2 & s.s3) | (s.q & (s.s2 | s.s3));
    end

    // registers
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_sync = s.q;
endmodule : ssr_sync

// ### logic/ssr_top.sv
// Purpose: safe position, message logging and stop-one reset/restart
// Assumes: position and message inputs are on i_sys_clk; buttons are pins
// Notes:   history depth must be a power of two; lamp half period >= 2
// Functional notes
// - safe position combines all position status and fault inputs
// - low safe position requests a stop, high means position safe
// - diagnostic suppression output high during second sensor self-test
// - up to eight monitored inputs, each with own output and message
// - configured edge gives one-cycle output pulse and a history entry
// - inputs one and two rise-triggered, three and four fall-triggered
// - emergency stop ok going low starts controlled stop one
// - reset enable only after reset pulse of at least 100 ms
// - reset enable is the release condition of the restart stage
// - release input leaving high starts controlled stop one
// - restart accepted only after a complete valid reset sequence
// - restart enable only after restart pulse of at least 100 ms
// - restart enable drives active-low stop one request flag
// - restart enable ANDed with external stop one request input
// - reset and restart required outputs blink 1 Hz while waiting
module ssr_top
    import ssr_pkg::*;
#(
    parameter int unsigned PULSE_CYC = PULSE_MIN_CYC,
    parameter int unsigned LAMP_CYC = LAMP_HALF_CYC,
    parameter int unsigned MSG_N = MSG_INPUTS,
    parameter int unsigned HIST_N = HIST_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire ssr_pos_in_t i_pos,
    input wire logic i_estop_ok,
    input wire logic i_stop1_reset_request,
    input wire logic i_stop1_restart_request,
    input wire logic i_external_stop1_request_n,
    input wire logic [MSG_N-1:0] i_msg_in,
    output logic o_safe_position,
    output logic o_position_valid,
    output logic o_inhibit_diag,
    output logic [MSG_N-1:0] o_msg_pulse,
    output logic o_reset_enable,
    output logic o_restart_enable,
    output logic o_stop1_request_n,
    output logic o_motion_stop1_ok,
    output logic o_reset_required,
    output logic o_restart_required,
    output logic o_irq,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack
);
    // ==================================================================
    // state
    localparam int unsigned CW = $clog2(PULSE_CYC + 1);
    localparam int unsigned LW = $clog2(LAMP_CYC);
    localparam int unsigned PW = $clog2(HIST_N);

    typedef struct packed {
        ssr_stage_t stage;
        logic [CW-1:0] rst_cnt;
        logic [CW-1:0] rsr_cnt;
        logic [LW-1:0] lamp_cnt;
        logic blink;
        logic req_rst;
        logic req_rsr;
        logic safe;
        logic valid;
        logic inhibit;
        logic motion_ok;
        logic armed;
        logic [MSG_N-1:0] msg_prev;
        logic [MSG_N-1:0] msg_pulse;
        logic [MSG_N-1:0] edge_fall;
        logic [MSG_N-1:0] msg_en;
        logic [HIST_N-1:0][MSG_N-1:0] hist;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0] count;
        logic [EV_W-1:0] irq_st;
        logic [EV_W-1:0] irq_en;
        logic ack;
        logic [31:0] rdat;
    } ssr_st_t;

    ssr_st_t s;
    ssr_st_t next_s;
    ssr_pin_t pin;
    logic pos_good;

    // ==================================================================
    // pin synchronisers
    ssr_sync #(
        .W($bits(ssr_pin_t))
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_async({i_estop_ok, i_stop1_reset_request, i_stop1_restart_request}),
        .o_sync(pin)
    );

    // every status good, no fault, no self-test
    assign pos_good = i_pos.monitor_ok & i_pos.cross_check_ok
        & i_pos.absolute_position_trust & ~i_pos.plausibility_fault
        & ~i_pos.second_sensor_selftest_fault & ~i_pos.sensor_identity_fault
        & ~i_pos.second_sensor_selftest_on;

    // ==================================================================
    // next state
    always_comb begin
        logic [MSG_N-1:0] rise;
        logic [MSG_N-1:0] fall;
        logic [MSG_N-1:0] fire;
        logic [EV_W-1:0] ev;
        logic [EV_W-1:0] clr;
        logic rst_ok;
        logic rsr_ok;
        logic push;
        logic pop;
        logic full;
        logic req;
        logic [31:0] rd;
        next_s = s;
        rise = '0;
        fall = '0;
        fire = '0;
        ev = '0;
        clr = '0;
        rst_ok = 1'b0;
        rsr_ok = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        full = 1'b0;
        req = 1'b0;
        rd = '0;

        next_s.safe = pos_good;
        next_s.valid = ~i_pos.second_sensor_selftest_on;
        next_s.inhibit = i_pos.second_sensor_selftest_on;
        // losing safe position is a stop request worth an event
        ev[EV_UNSAFE] = s.safe & ~pos_good;

        // edge choice per input, falling where bit set
        rise = i_msg_in & ~s.msg_prev;
        fall = ~i_msg_in & s.msg_prev;
        // each input masked and pulsed on its own output
        fire = ((rise & ~s.edge_fall) | (fall & s.edge_fall)) & s.msg_en;
        // first cycle after reset has no valid previous sample
        fire = s.armed ? fire : '0;
        next_s.armed = 1'b1;
        next_s.msg_prev = i_msg_in;
        // one-cycle pulse and one history entry
        next_s.msg_pulse = fire;
        push = |fire;
        ev[EV_MSG] = push;

        // count cycles while held, judge on release
        if (pin.stop1_reset_request && pin.estop_ok && s.stage == STG_STOPPED) begin
            if (s.rst_cnt != '1) begin
                next_s.rst_cnt = s.rst_cnt + 1'b1;
            end
        end else begin
            rst_ok = pin.estop_ok && s.stage == STG_STOPPED && (s.rst_cnt >= PULSE_CYC);
            next_s.rst_cnt = '0;
        end
        // restart counts only with reset stage enabled
        if (pin.stop1_restart_request && s.stage == STG_RESET_OK && pin.estop_ok) begin
            if (s.rsr_cnt != '1) begin
                next_s.rsr_cnt = s.rsr_cnt + 1'b1;
            end
        end else begin
            rsr_ok = pin.estop_ok && s.stage == STG_RESET_OK && (s.rsr_cnt >= PULSE_CYC);
            next_s.rsr_cnt = '0;
        end

        // reset and restart stages
        case (s.stage)
            STG_STOPPED: begin
                if (rst_ok) begin
                    next_s.stage = STG_RESET_OK;
                end
            end
            STG_RESET_OK: begin
                // emergency stop drop cancels the reset
                if (!pin.estop_ok) begin
                    next_s.stage = STG_STOPPED;
                end else if (rsr_ok) begin
                    // run only from a completed reset
                    next_s.stage = STG_RUN;
                end
            end
            STG_RUN: begin
                if (!pin.estop_ok) begin
                    next_s.stage = STG_STOPPED;
                end
            end
            default: begin
                next_s.stage = STG_STOPPED;
            end
        endcase
        ev[EV_RESET] = rst_ok;
        ev[EV_RESTART] = rsr_ok && pin.estop_ok;
        ev[EV_STOP] = (s.stage == STG_RUN) && (next_s.stage != STG_RUN);
        // external request can also stop motion
        next_s.motion_ok = (next_s.stage == STG_RUN) & i_external_stop1_request_n;

        if (s.lamp_cnt == LW'(LAMP_CYC - 1)) begin
            next_s.lamp_cnt = '0;
            next_s.blink = ~s.blink;
        end else begin
            next_s.lamp_cnt = s.lamp_cnt + 1'b1;
        end
        // lamps follow the coming stage, so a lamp never lights beside its own enable
        next_s.req_rst = s.blink & pin.estop_ok & (next_s.stage == STG_STOPPED);
        next_s.req_rsr = s.blink & (next_s.stage == STG_RESET_OK);

        // bus slave: one wait state, ack drops after one cycle
        req = i_wb_cyc & i_wb_stb & ~s.ack;
        next_s.ack = req;
        case (i_wb_adr[7:2])
            ADDR_STATUS[7:2]: begin
                rd[ST_SAFE] = s.safe;
                rd[ST_INHIBIT] = s.inhibit;
                rd[ST_RESET_EN] = s.stage != STG_STOPPED;
                rd[ST_RESTART_EN] = s.stage == STG_RUN;
                rd[ST_ESTOP] = pin.estop_ok;
                rd[ST_MOTION] = s.motion_ok;
            end
            ADDR_MSG_EDGE[7:2]: rd[MSG_N-1:0] = s.edge_fall;
            ADDR_MSG_EN[7:2]: rd[MSG_N-1:0] = s.msg_en;
            ADDR_HIST[7:2]: begin
                rd[MSG_N-1:0] = (s.count != '0) ? s.hist[s.rd_ptr] : '0;
                rd[HIST_VALID] = s.count != '0;
                // reading an entry removes it
                pop = req & ~i_wb_we & (s.count != '0);
            end
            ADDR_HIST_CNT[7:2]: rd[PW:0] = s.count;
            ADDR_IRQ_ST[7:2]: rd[EV_W-1:0] = s.irq_st;
            ADDR_IRQ_EN[7:2]: rd[EV_W-1:0] = s.irq_en;
            default: rd = '0;
        endcase
        if (req) begin
            next_s.rdat = i_wb_we ? '0 : rd;
        end
        if (req && i_wb_we && i_wb_sel[0]) begin
            case (i_wb_adr[7:2])
                ADDR_MSG_EDGE[7:2]: next_s.edge_fall = i_wb_dat[MSG_N-1:0];
                ADDR_MSG_EN[7:2]: next_s.msg_en = i_wb_dat[MSG_N-1:0];
                ADDR_IRQ_CLR[7:2]: clr = i_wb_dat[EV_W-1:0];
                ADDR_IRQ_EN[7:2]: next_s.irq_en = i_wb_dat[EV_W-1:0];
                default: clr = '0;
            endcase
        end

        // history ring: a full ring drops its oldest entry
        full = s.count == (PW + 1)'(HIST_N);
        if (push) begin
            next_s.hist[s.wr_ptr] = fire;
            next_s.wr_ptr = s.wr_ptr + 1'b1;
        end
        if (pop || (push && full)) begin
            next_s.rd_ptr = s.rd_ptr + 1'b1;
        end
        if (push && !pop && !full) begin
            next_s.count = s.count + 1'b1;
        end else if (pop && !push) begin
            next_s.count = s.count - 1'b1;
        end

        // sticky events: a new event beats a clear in the same cycle
        next_s.irq_st = (s.irq_st & ~clr) | ev;
    end

    // ==================================================================
    // registers
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            s <= '0;
            s.edge_fall <= MSG_EDGE_RST[MSG_N-1:0];
            s.msg_en <= MSG_EN_RST[MSG_N-1:0];
        end else begin
            s <= next_s;
        end
    end

    assign o_safe_position = s.safe;
    assign o_position_valid = s.valid;
    assign o_inhibit_diag = s.inhibit;
    assign o_msg_pulse = s.msg_pulse;
    assign o_reset_enable = s.stage != STG_STOPPED;
    assign o_restart_enable = s.stage == STG_RUN;
    // low while stop one is requested
    assign o_stop1_request_n = s.stage == STG_RUN;
    assign o_motion_stop1_ok = s.motion_ok;
    assign o_reset_required = s.req_rst;
    assign o_restart_required = s.req_rsr;
    assign o_irq = |(s.irq_st & s.irq_en);
    assign o_wb_dat = s.rdat;
    assign o_wb_ack = s.ack;

    // ==================================================================
    // assertions
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    sequence selftest_start;
        $rose(i_pos.second_sensor_selftest_on);
    endsequence
    sequence blind_window;
        !o_safe_position && o_inhibit_diag && !o_position_valid;
    endsequence
    sequence estop_drop;
        !pin.estop_ok;
    endsequence

    selftest_blind_a: assert property (selftest_start |=> blind_window)
        else $error("self-test did not blind position");
    selftest_invalid_a: assert property (i_pos.second_sensor_selftest_on |=> !o_position_valid)
        else $error("position valid during self-test");
    safe_good_a: assert property (i_rstn && pos_good |=> o_safe_position)
        else $error("safe position low with all inputs good");
    safe_fault_a: assert property (i_pos.plausibility_fault |=> !o_safe_position)
        else $error("safe position high with a fault");
    msg_once_a: assert property ((o_msg_pulse & $past(o_msg_pulse)) == '0)
        else $error("message pulse longer than one cycle");
    msg_logged_a: assert property (|o_msg_pulse |-> s.count != '0)
        else $error("message pulse without history entry");
    msg_fall_a: assert property (s.armed && s.msg_en[2] && s.edge_fall[2]
        && $fell(i_msg_in[2]) |=> o_msg_pulse[2])
        else $error("falling edge missed on input three");
    estop_stop_a: assert property (estop_drop |=> !o_restart_enable && !o_motion_stop1_ok)
        else $error("stop one not started on emergency stop");
    reset_pulse_a: assert property ($rose(o_reset_enable) |-> $past(s.rst_cnt) >= PULSE_CYC)
        else $error("reset accepted on short pulse");
    restart_order_a: assert property (o_restart_enable |-> o_reset_enable)
        else $error("restart without reset");
    restart_pulse_a: assert property ($rose(o_restart_enable) |-> $past(s.rsr_cnt) >= PULSE_CYC)
        else $error("restart accepted on short pulse");
    stop_flag_a: assert property (o_motion_stop1_ok |-> o_stop1_request_n)
        else $error("motion released while stop one requested");
    stop_ext_a: assert property (!i_external_stop1_request_n |=> !o_motion_stop1_ok)
        else $error("external stop one request ignored");
    lamp_a: assert property (o_reset_required |-> !o_reset_enable && !o_restart_required)
        else $error("reset lamp while reset done");
endmodule : ssr_top

// ### verification/ssr_partner.sv
// Purpose: operator button model for the stop one reset and restart stages
// Assumes: one press at a time, commanded by the bench
// Notes:   a released contact reads low; no bounce is modelled
module ssr_partner (
    input wire logic i_sys_clk,
    input wire logic i_go,
    input wire logic i_sel,
    input wire logic [15:0] i_len,
    output logic o_reset_btn,
    output logic o_restart_btn
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================================
    // press timing
    logic [15:0] left;
    logic which;
    initial begin
        left = 16'h0000;
        which = 1'b0;
    end
    always @(posedge i_sys_clk) begin
        if (i_go) begin
            left <= i_len;
            which <= i_sel;
        end else if (left != 16'h0000) begin
            left <= left - 16'h0001;
        end
    end
    // one button at a time, so the stages never see a double press
    assign o_reset_btn = (left != 16'h0000) && !which;
    assign o_restart_btn = (left != 16'h0000) && which;
endmodule : ssr_partner

// ### verification/tb_top.sv
// Purpose: self-checking bench of the safe position and stop reset block
// Assumes: short pulse and lamp counts so the run stays brief
// Notes:   all inputs move by non-blocking assignment at the rising edge
module tb_top;
    import ssr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PC = 20;
    logic clk, rstn, estop, ext_n, cyc, stb, we, go, sel;
    logic rst_btn, rs_btn, safe, valid, inh, r_en, s_en, s1n, mot, r_req, s_req, irq, ack;
    logic [15:0] len;
    logic [7:0] adr, msg, pls;
    logic [31:0] wdat, rdat, q;
    ssr_pos_in_t pos;
    int mismatches, n_tests;
    // ==================================================================
    // design and button model
    ssr_top #(.PULSE_CYC(PC), .LAMP_CYC(4), .MSG_N(8), .HIST_N(8)) u_ssr_top (
        .i_sys_clk(clk), .i_rstn(rstn), .i_pos(pos), .i_estop_ok(estop),
        .i_stop1_reset_request(rst_btn), .i_stop1_restart_request(rs_btn),
        .i_external_stop1_request_n(ext_n), .i_msg_in(msg), .o_safe_position(safe),
        .o_position_valid(valid), .o_inhibit_diag(inh), .o_msg_pulse(pls),
        .o_reset_enable(r_en), .o_restart_enable(s_en), .o_stop1_request_n(s1n),
        .o_motion_stop1_ok(mot), .o_reset_required(r_req), .o_restart_required(s_req),
        .o_irq(irq), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat), .o_wb_ack(ack));
    ssr_partner u_ssr_partner (.i_sys_clk(clk), .i_go(go), .i_sel(sel), .i_len(len),
        .o_reset_btn(rst_btn), .o_restart_btn(rs_btn));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==================================================================
    // shared tasks
    task stop_test();
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
            mismatches++;
        end
    endtask : chk
    task cyc_n(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc_n
    // classic cycle: hold everything until ack is seen at an edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin mismatches++; stop_test(); end
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task wait_en(input logic w, input logic v);
        int n;
        n = 0;
        while ((w ? s_en : r_en) !== v && n < 200) begin @(posedge clk); n++; end
        if (n >= 200) begin mismatches++; stop_test(); end
    endtask : wait_en
    // count lamp highs over 16 cycles: blinking or dark
    task lamp(input logic w, input logic blinks);
        int hi;
        hi = 0;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            hi += int'((w ? s_req : r_req) === 1'b1);
        end
        chk(32'(blinks ? (hi > 0 && hi < 16) : (hi == 0)), 32'h1);
    endtask : lamp
    task press(input logic s, input int l);
        go <= 1'b1; sel <= s; len <= 16'(l);
        @(posedge clk);
        go <= 1'b0;
        cyc_n(l + 12);
    endtask : press
    // ==================================================================
    // scenarios
    task t_regs();
        wb(1'b0, ADDR_MSG_EDGE, 32'h0); chk(q, {24'h0, MSG_EDGE_RST});
        wb(1'b0, ADDR_MSG_EN, 32'h0); chk(q, {24'h0, MSG_EN_RST});
        wb(1'b0, ADDR_IRQ_EN, 32'h0); chk(q, 32'h0);
        wb(1'b0, 8'h40, 32'h0); chk(q, 32'h0);
    endtask : t_regs
    task t_pos();
        logic [6:0] v;
        for (int b = -1; b < 7; b++) begin
            v = (b < 0) ? 7'h70 : (7'h70 ^ (7'h01 << b));
            pos <= ssr_pos_in_t'(v);
            cyc_n(3);
            chk({31'h0, safe}, {31'h0, b < 0});
            chk({31'h0, inh}, {31'h0, v[0]});
            chk({31'h0, valid}, {31'h0, !v[0]});
        end
        pos <= ssr_pos_in_t'(7'h70);
    endtask : t_pos
    task t_msg();
        wb(1'b1, ADDR_IRQ_EN, 32'h1 << EV_MSG);
        for (int i = 0; i < 8; i++) begin
            msg[i] <= ~MSG_EDGE_RST[i];
            cyc_n(2);
            chk({24'h0, pls}, 32'h1 << i);
            cyc_n(1);
            chk({24'h0, pls}, 32'h0);
            msg[i] <= MSG_EDGE_RST[i];
            cyc_n(3);
            chk({24'h0, pls}, 32'h0);
        end
        wb(1'b0, ADDR_HIST_CNT, 32'h0); chk(q, 32'h8);
        wb(1'b0, ADDR_HIST, 32'h0); chk(q, 32'h101);
        wb(1'b0, ADDR_HIST_CNT, 32'h0); chk(q, 32'h7);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, ADDR_IRQ_CLR, 32'h1f);
        chk({31'h0, irq}, 32'h0);
    endtask : t_msg
    task t_stage();
        lamp(1'b0, 1'b1);
        lamp(1'b1, 1'b0);
        press(1'b1, PC + 10); chk({31'h0, s_en}, 32'h0);
        press(1'b0, PC / 2); chk({31'h0, r_en}, 32'h0);
        press(1'b0, PC + 10); wait_en(1'b0, 1'b1); chk({31'h0, r_en}, 32'h1);
        chk({31'h0, s_en}, 32'h0);
        lamp(1'b1, 1'b1);
        lamp(1'b0, 1'b0);
        press(1'b1, PC + 10); wait_en(1'b1, 1'b1); chk({31'h0, s_en}, 32'h1);
        cyc_n(2);
        chk({31'h0, s1n}, 32'h1);
        chk({31'h0, mot}, 32'h1);
        ext_n <= 1'b0; cyc_n(3); chk({31'h0, mot}, 32'h0);
        ext_n <= 1'b1; cyc_n(3); chk({31'h0, mot}, 32'h1);
        wb(1'b0, ADDR_STATUS, 32'h0); chk(q, 32'h3d);
        estop <= 1'b0; wait_en(1'b0, 1'b0); cyc_n(2);
        chk({29'h0, s_en, s1n, mot}, 32'h0);
        wb(1'b0, ADDR_IRQ_ST, 32'h0); chk(q & 32'h7, 32'h7);
        estop <= 1'b1;
    endtask : t_stage
    // ==================================================================
    // main sequence
    initial begin
        mismatches = 0; n_tests = 0;
        rstn = 1'b0; estop = 1'b1; ext_n = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0;
        go = 1'b0; sel = 1'b0; len = 16'h0; adr = 8'h00; wdat = 32'h0;
        msg = MSG_EDGE_RST; pos = ssr_pos_in_t'(7'h70);
        cyc_n(8);
        rstn <= 1'b1;
        cyc_n(6);
        t_regs();
        t_pos();
        t_msg();
        t_stage();
        stop_test();
    end
endmodule : tb_top
